//--- hw/hpw_ctrl.sv
// Purpose: halt power mode selection, clock gating, flags and wake-up control
// Assumes: cpu pulses haltExec and clrWdtExec for one cycle; port A pins asynchronous
// Notes: Operation
`timescale 1ns/100ps
`include "hpw_regs.svh"
module hpw_ctrl #(
	parameter int WDT_TICKS = `HPW_WDT_TICKS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// register bus
	input hpw_pkg::hpw_avm_req_s avsReq,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// cpu side
	input wire logic haltExec,
	input wire logic clrWdtExec,
	input wire logic [7:0] intReqFlags,
	input wire logic [7:0] intEnables,
	input wire logic stackFull,
	// port A pins
	input wire logic [7:0] portAPin,
	// power and clock control
	output logic cpuRun,
	output logic hsClkEn,
	output logic subClkEn,
	output logic lsOscEn,
	output logic resumeNext,
	output logic intResponse,
	output logic pcSpReset,
	output logic wdtResetReq,
	output logic powerDownFlag,
	output logic wdtExpiryFlag,
	output logic irq
);
	import hpw_pkg::*;

	localparam logic [8:0] STAB_LAST = 9'(`HPW_HS_STAB_CYC - 1);
	localparam logic [8:0] LS_LAST = 9'(`HPW_LS_DIV_CYC - 1);
	localparam logic [15:0] WDT_LAST = 16'(WDT_TICKS - 1);

	hpw_state_s r, n;
	logic req, access, lsTick, wdtOvf, pinWake, intWake, hsOn;
	logic [7:0] agree, newLvl, pinFall, freshInt;
	logic [31:0] rd;

	// bus handshake: one wait cycle, access completes where waitrequest is low
	assign req = avsReq.read | avsReq.write;
	assign access = req & ~r.waitReq;

	// filtered port A: a level counts once second and third stages agree
	assign agree = ~(r.sync2 ^ r.sync3);
	assign newLvl = (agree & r.sync3) | (~agree & r.pinLvl);
	assign pinFall = r.pinLvl & ~newLvl;
	assign pinWake = |(pinFall & r.wakeEn);
	// only requests raised after halt entry may wake
	assign freshInt = intReqFlags & ~r.pendAtHalt;
	assign intWake = |freshInt;
	assign lsTick = r.lsOscEn && (r.lsDiv == LS_LAST);
	assign wdtOvf = r.wdtEnable && lsTick && (r.wdtCnt == WDT_LAST);

	// read mux, sampled one cycle before the access completes
	always_comb begin
		rd = 32'h0000_0000;
		case (avsReq.address)
			`HPW_OFS_CLKCTL: begin
				rd[`HPW_SLOWKEEP_BIT] = r.keep[0];
				rd[`HPW_FASTKEEP_BIT] = r.keep[1];
			end
			`HPW_OFS_HSOSC: begin
				rd[`HPW_HSEN_BIT] = r.hsEnable;
				rd[`HPW_HSSTABLE_BIT] = r.hsStable;
			end
			`HPW_OFS_PAWAKE: rd[7:0] = r.wakeEn;
			`HPW_OFS_STATUS: begin
				rd[`HPW_PWRDN_BIT] = r.pwrDown;
				rd[`HPW_EXPIRY_BIT] = r.expiry;
			end
			`HPW_OFS_WDTCTL: rd[0] = r.wdtEnable;
			`HPW_OFS_EVSTAT: rd[2:0] = r.evStat;
			`HPW_OFS_EVMASK: rd[2:0] = r.evMask;
			`HPW_OFS_MODE: rd[2:0] = r.mode;
			default: rd = 32'h0000_0000;
		endcase
	end

	// next state of the whole controller
	always_comb begin
		n = r;
		n.resumeNext = 1'b0;
		n.intResponse = 1'b0;
		n.pcSpReset = 1'b0;
		n.wdtResetReq = 1'b0;
		// bus slave
		n.waitReq = ~(req & r.waitReq);
		if (req && r.waitReq && avsReq.read) begin
			n.rdata = rd;
		end
		if (access && avsReq.write) begin
			case (avsReq.address)
				`HPW_OFS_CLKCTL: begin
					n.keep[0] = avsReq.writedata[`HPW_SLOWKEEP_BIT];
					n.keep[1] = avsReq.writedata[`HPW_FASTKEEP_BIT];
				end
				`HPW_OFS_HSOSC: n.hsEnable = avsReq.writedata[`HPW_HSEN_BIT];
				`HPW_OFS_PAWAKE: n.wakeEn = avsReq.writedata[7:0];
				`HPW_OFS_WDTCTL: n.wdtEnable = avsReq.writedata[0];
				`HPW_OFS_EVSTAT: n.evStat = r.evStat & ~avsReq.writedata[2:0];
				`HPW_OFS_EVMASK: n.evMask = avsReq.writedata[2:0];
				default: n.rdata = r.rdata;
			endcase
		end
		// pin synchroniser; first stage feeds only the second
		n.sync1 = portAPin;
		n.sync2 = r.sync1;
		n.sync3 = r.sync2;
		n.pinLvl = newLvl;
		// low-speed tick divider, runs while the slow oscillator is on
		n.lsDiv = (!r.lsOscEn || lsTick) ? 9'h000 : 9'(r.lsDiv + 9'h001);
		// watchdog counter
		if (clrWdtExec || wdtOvf) begin
			n.wdtCnt = 16'h0000;
		end else if (r.wdtEnable && lsTick) begin
			n.wdtCnt = 16'(r.wdtCnt + 16'h0001);
		end
		if (clrWdtExec) begin
			n.pwrDown = 1'b0;
		end
		if (wdtOvf) begin
			n.expiry = 1'b1;
			n.evStat[`HPW_EV_WDT_BIT] = 1'b1;
		end
		case (r.st)
			PM_RUN: begin
				if (wdtOvf) begin
					n.wdtResetReq = 1'b1; // full device reset is taken elsewhere
				end
				if (haltExec) begin
					n.st = PM_HALT;
					n.cpuRun = 1'b0;
					// mode from the keep bits of this very cycle
					case (r.keep)
						2'b00: n.mode = MD_SLEEP;
						2'b01: n.mode = MD_IDLE_SUB_ONLY;
						2'b11: n.mode = MD_IDLE_BOTH;
						default: n.mode = MD_IDLE_FAST_ONLY;
					endcase
					n.pwrDown = 1'b1; // set wins over clear-watchdog
					n.expiry = wdtOvf; // a coincident overflow still sets it
					n.wdtCnt = 16'h0000;
					n.pendAtHalt = intReqFlags;
					n.evStat[`HPW_EV_HALT_BIT] = 1'b1;
				end
			end
			PM_HALT: begin
				// overflow first, then interrupt, then pin
				if (wdtOvf || intWake || pinWake) begin
					n.st = PM_WAKE;
					n.evStat[`HPW_EV_WAKE_BIT] = 1'b1;
					if (wdtOvf) begin
						n.cause = WK_WDT;
					end else if (intWake) begin
						n.cause = WK_INT;
						n.svcInt = (|(freshInt & intEnables)) && !stackFull;
					end else begin
						n.cause = WK_PIN;
					end
				end
			end
			PM_WAKE: begin
				// the original oscillator must settle before code runs
				if (r.hsStable || !r.hsEnable) begin
					n.st = PM_RUN;
					n.mode = MD_ACTIVE;
					n.cpuRun = 1'b1;
					n.pendAtHalt = 8'h00;
					case (r.cause)
						WK_WDT: n.pcSpReset = 1'b1;
						WK_INT: begin
							n.intResponse = r.svcInt;
							n.resumeNext = !r.svcInt;
						end
						default: n.resumeNext = 1'b1;
					endcase
				end
			end
			default: n.st = PM_RUN;
		endcase
		// oscillator and clock gating follow the next state
		hsOn = n.hsEnable && ((n.st != PM_HALT) || (n.mode == MD_IDLE_BOTH) ||
			(n.mode == MD_IDLE_FAST_ONLY));
		if (!hsOn) begin
			n.hsStable = 1'b0;
			n.stabCnt = 9'h000;
		end else if (!r.hsStable) begin
			n.stabCnt = 9'(r.stabCnt + 9'h001);
			n.hsStable = (r.stabCnt == STAB_LAST);
		end
		n.hsClkEn = hsOn && n.hsStable;
		n.subClkEn = (n.st != PM_HALT) || (n.mode == MD_IDLE_SUB_ONLY) ||
			(n.mode == MD_IDLE_BOTH);
		// sleep keeps the slow oscillator alive only while the watchdog is enabled
		n.lsOscEn = n.subClkEn || n.wdtEnable;
		n.irq = |(n.evStat & n.evMask);
	end

	// single state register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
			r.st <= PM_RUN;
			r.mode <= MD_ACTIVE;
			r.cause <= WK_PIN;
			r.keep <= `HPW_CLKCTL_RST;
			r.hsEnable <= `HPW_HSEN_RST;
			r.wakeEn <= `HPW_PAWAKE_RST;
			r.wdtEnable <= `HPW_WDTEN_RST;
			r.evMask <= `HPW_EVMASK_RST;
			r.sync1 <= 8'hFF;
			r.sync2 <= 8'hFF;
			r.sync3 <= 8'hFF;
			r.pinLvl <= 8'hFF;
			r.waitReq <= 1'b1;
			r.cpuRun <= 1'b1;
			r.subClkEn <= 1'b1;
			r.lsOscEn <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.waitReq;
	assign cpuRun = r.cpuRun;
	assign hsClkEn = r.hsClkEn;
	assign subClkEn = r.subClkEn;
	assign lsOscEn = r.lsOscEn;
	assign resumeNext = r.resumeNext;
	assign intResponse = r.intResponse;
	assign pcSpReset = r.pcSpReset;
	assign wdtResetReq = r.wdtResetReq;
	assign powerDownFlag = r.pwrDown;
	assign wdtExpiryFlag = r.expiry;
	assign irq = r.irq;

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	sleep_clocks_a: assert property (r.st == PM_RUN && haltExec && r.keep == 2'b00 |=>
		!hsClkEn && !subClkEn && lsOscEn == r.wdtEnable)
		else $error("sleep left a clock running");
	idle_sub_a: assert property (r.st == PM_RUN && haltExec && r.keep == 2'b01 |=>
		!hsClkEn && subClkEn)
		else $error("sub-only idle clocks wrong");
	idle_both_a: assert property (r.st == PM_RUN && haltExec && r.keep == 2'b11 &&
		hsClkEn |=> hsClkEn && subClkEn && !cpuRun)
		else $error("both-clock idle clocks wrong");
	idle_fast_a: assert property (r.st == PM_RUN && haltExec && r.keep == 2'b10 &&
		hsClkEn |=> hsClkEn && !subClkEn)
		else $error("fast-only idle clocks wrong");
	halt_hold_a: assert property (r.st != PM_RUN |-> !cpuRun)
		else $error("cpu runs while halted");
	halt_flags_a: assert property (r.st == PM_RUN && haltExec && !wdtOvf |=>
		powerDownFlag && !wdtExpiryFlag && r.wdtCnt == 16'h0000)
		else $error("halt entry flags or counter wrong");
	wake_source_a: assert property (r.st == PM_HALT && (pinWake || intWake || wdtOvf) |=>
		r.st == PM_WAKE)
		else $error("wake event missed");
	pdf_clear_a: assert property ($fell(powerDownFlag) |-> $past(clrWdtExec))
		else $error("power-down flag cleared without clear-watchdog");
	wdt_wake_a: assert property (r.st == PM_HALT && wdtOvf |=> wdtExpiryFlag ##0
		(r.st == PM_WAKE) ##[1:300] pcSpReset)
		else $error("watchdog wake wrong");
	pend_ignore_a: assert property (r.st == PM_HALT && !pinWake && !wdtOvf &&
		freshInt == 8'h00 |=> r.st == PM_HALT)
		else $error("stale interrupt woke the device");
	stable_wait_a: assert property (r.st == PM_WAKE && r.hsEnable && !r.hsStable |=>
		!cpuRun)
		else $error("resumed before oscillator stable");
	stable_flag_a: assert property ($rose(r.hsEnable) |=> !r.hsStable [*2])
		else $error("stable flag not cleared on enable");
	int_path_a: assert property (intResponse |-> !resumeNext && !pcSpReset)
		else $error("two resume paths at once");

	// bus handshake: a waiting request is answered next cycle, low lasts one cycle
	bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	bus_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	// a stopped watchdog only ever moves back to zero
	wdt_stop_a: assert property (!r.wdtEnable |=> $stable(r.wdtCnt) || r.wdtCnt == 16'h0000)
		else $error("disabled watchdog counted");
	pdf_hold_a: assert property (powerDownFlag && !clrWdtExec |=> powerDownFlag)
		else $error("power-down flag lost");
	pc_reset_a: assert property (pcSpReset |-> wdtExpiryFlag && cpuRun)
		else $error("pc reset without expiry flag");
	pin_resume_a: assert property (resumeNext |-> cpuRun && !pcSpReset)
		else $error("resume pulse while halted");
	int_cause_a: assert property (r.st == PM_HALT && !wdtOvf && intWake |=>
		r.cause == WK_INT)
		else $error("interrupt wake cause wrong");
	hs_gate_a: assert property (hsClkEn |-> r.hsStable)
		else $error("fast clock gated on before stable");
	run_clocks_a: assert property (cpuRun |-> subClkEn && lsOscEn)
		else $error("running cpu without sub clock");

	sleep_enter_c: cover property (r.st == PM_RUN && haltExec && r.keep == 2'b00);
	pin_wake_c: cover property (r.st == PM_HALT && pinWake ##[1:400] resumeNext);
	int_svc_c: cover property (r.st == PM_HALT ##1 intResponse);
	wdt_wake_c: cover property (r.st == PM_HALT && wdtOvf);
	// overflow while running goes out as a device reset request
	wdt_run_c: cover property (wdtResetReq);
endmodule // hpw_ctrl

//--- hw/hpw_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on a 6-bit Avalon address, one 32-bit word per register
// Notes: definitions only
`ifndef HPW_REGS_SVH
`define HPW_REGS_SVH
`define HPW_OFS_CLKCTL 6'h00
`define HPW_OFS_HSOSC 6'h04
`define HPW_OFS_PAWAKE 6'h08
`define HPW_OFS_STATUS 6'h0C
`define HPW_OFS_WDTCTL 6'h10
`define HPW_OFS_EVSTAT 6'h14
`define HPW_OFS_EVMASK 6'h18
`define HPW_OFS_MODE 6'h1C
`define HPW_SLOWKEEP_BIT 0
`define HPW_FASTKEEP_BIT 1
`define HPW_HSEN_BIT 0
`define HPW_HSSTABLE_BIT 1
`define HPW_PWRDN_BIT 0
`define HPW_EXPIRY_BIT 1
`define HPW_EV_HALT_BIT 0
`define HPW_EV_WAKE_BIT 1
`define HPW_EV_WDT_BIT 2
`define HPW_CLKCTL_RST 2'h0
`define HPW_HSEN_RST 1'h1
`define HPW_PAWAKE_RST 8'h00
`define HPW_WDTEN_RST 1'h1
`define HPW_EVMASK_RST 3'h0
`define HPW_CLK_NS 100
`define HPW_HS_STAB_NS 25600
`define HPW_HS_STAB_CYC ((`HPW_HS_STAB_NS + `HPW_CLK_NS - 1) / `HPW_CLK_NS)
`define HPW_LS_PERIOD_NS 31250
`define HPW_LS_DIV_CYC (`HPW_LS_PERIOD_NS / `HPW_CLK_NS)
`define HPW_WDT_TICKS 256
`endif

//--- hw/hpw_pkg.sv
// Purpose: types shared by the halt power mode controller
// Assumes: constants come from hpw_regs.svh
// Notes: none
package hpw_pkg;
	typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_WAKE} hpw_state_e;
	typedef enum logic [2:0] {MD_ACTIVE, MD_SLEEP, MD_IDLE_SUB_ONLY, MD_IDLE_BOTH,
		MD_IDLE_FAST_ONLY} hpw_mode_e;
	typedef enum logic [1:0] {WK_PIN, WK_INT, WK_WDT} hpw_cause_e;
	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
	} hpw_avm_req_s;
	typedef struct packed {
		hpw_state_e st;
		hpw_mode_e mode;
		hpw_cause_e cause;
		logic svcInt;
		logic [1:0] keep;
		logic hsEnable;
		logic hsStable;
		logic [8:0] stabCnt;
		logic [7:0] wakeEn;
		logic wdtEnable;
		logic [15:0] wdtCnt;
		logic [8:0] lsDiv;
		logic pwrDown;
		logic expiry;
		logic [7:0] pendAtHalt;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] pinLvl;
		logic [2:0] evStat;
		logic [2:0] evMask;
		logic irq;
		logic waitReq;
		logic [31:0] rdata;
		logic cpuRun;
		logic hsClkEn;
		logic subClkEn;
		logic lsOscEn;
		logic resumeNext;
		logic intResponse;
		logic pcSpReset;
		logic wdtResetReq;
	} hpw_state_s;
endpackage

//--- dv/hpw_ctrl_bench.sv
// Purpose: self-checking bench for the halt power mode controller
// Assumes: watchdog shortened to 4 ticks; cpu, pins and bus driven by this bench
// Notes: each keep-bit setting is halted and woken; expected values are literals or are taken from the loop index
`timescale 1ns/100ps
`include "hpw_regs.svh"
module hpw_ctrl_bench;
	import hpw_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	hpw_avm_req_s avsReq = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic haltExec = 1'b0;
	logic clrWdtExec = 1'b0;
	logic [7:0] intReqFlags = 8'h00;
	logic [7:0] intEnables = 8'h00;
	logic stackFull = 1'b0;
	logic [7:0] portAPin = 8'hFF;
	logic cpuRun, hsClkEn, subClkEn, lsOscEn, resumeNext, intResponse, pcSpReset;
	logic wdtResetReq, powerDownFlag, wdtExpiryFlag, irq;
	logic [31:0] rd;
	logic [31:0] md [4] = '{32'h1, 32'h2, 32'h4, 32'h3};
	int err_total = 0;
	int comparisons = 0;
	int w;

	// short watchdog so an overflow wake fits in the run
	hpw_ctrl #(.WDT_TICKS(4)) i_dut (
		.core_clk(core_clk), .arst_n(arst_n), .avsReq(avsReq),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.haltExec(haltExec), .clrWdtExec(clrWdtExec), .intReqFlags(intReqFlags),
		.intEnables(intEnables), .stackFull(stackFull), .portAPin(portAPin),
		.cpuRun(cpuRun), .hsClkEn(hsClkEn), .subClkEn(subClkEn), .lsOscEn(lsOscEn),
		.resumeNext(resumeNext), .intResponse(intResponse), .pcSpReset(pcSpReset),
		.wdtResetReq(wdtResetReq), .powerDownFlag(powerDownFlag),
		.wdtExpiryFlag(wdtExpiryFlag), .irq(irq)
	);

	// 100 ns clock
	always #50 core_clk = ~core_clk;

	// single place where the run ends
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one bus access; the request stands until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		avsReq <= '{read: !wr, write: wr, address: adr, writedata: wd};
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			give_verdict();
		end
		rd = avs_readdata;
		avsReq <= '0;
		// an edge passes so the next request is never set in the release step
		@(posedge core_clk);
	endtask

	// one-cycle halt pulse; returns just after the edge that took it
	task automatic halt_now();
		haltExec <= 1'b1;
		@(posedge core_clk);
		haltExec <= 1'b0;
		#1;
	endtask

	// bounded wait for the cpu to run again
	task automatic wait_run(input int lim);
		int n;
		n = 0;
		while (cpuRun !== 1'b1 && n < lim) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (cpuRun !== 1'b1) begin
			err_total++;
			give_verdict();
		end
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		bus(1'b0, `HPW_OFS_CLKCTL, 32'h0);
		check("keep bits reset", rd, 32'h0);
		bus(1'b0, `HPW_OFS_HSOSC, 32'h0);
		check("hs osc settling", rd, 32'h1);
		repeat (260) @(posedge core_clk);
		bus(1'b0, `HPW_OFS_HSOSC, 32'h0);
		check("hs osc stable", rd, 32'h3);
		bus(1'b0, 6'h3C, 32'h0);
		check("unmapped read", rd, 32'h0);
		// watchdog kept off so only the intended source wakes the early halts
		bus(1'b1, `HPW_OFS_WDTCTL, 32'h0);
		bus(1'b1, `HPW_OFS_PAWAKE, 32'h1);
		bus(1'b1, `HPW_OFS_EVMASK, 32'h4);
		// every keep-bit setting, woken by a pin fall
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `HPW_OFS_CLKCTL, 32'(k));
			halt_now();
			check("cpu stopped", cpuRun, 32'h0);
			check("power-down set", powerDownFlag, 32'h1);
			check("expiry cleared", wdtExpiryFlag, 32'h0);
			check("fast gate", hsClkEn, 32'(k[1]));
			check("sub gate", subClkEn, 32'(k[0]));
			check("slow osc", lsOscEn, 32'(k[0]));
			bus(1'b1, `HPW_OFS_CLKCTL, 32'(~k & 3));
			bus(1'b0, `HPW_OFS_MODE, 32'h0);
			check("mode", rd, md[k]);
			portAPin <= 8'hFE;
			wait_run(600);
			check("pin resume", resumeNext, 32'h1);
			check("clock back", hsClkEn, 32'h1);
			portAPin <= 8'hFF;
		end
		check("power-down kept", powerDownFlag, 32'h1);
		clrWdtExec <= 1'b1;
		@(posedge core_clk);
		clrWdtExec <= 1'b0;
		#1;
		check("power-down cleared", powerDownFlag, 32'h0);
		// interrupt wake: enabled, stack full, disabled
		for (int c = 0; c < 3; c++) begin
			intEnables <= (c == 2) ? 8'h00 : 8'h02;
			stackFull <= (c == 1);
			halt_now();
			intReqFlags <= 8'h02;
			wait_run(600);
			check("int response", intResponse, 32'(c == 0));
			check("int resume", resumeNext, 32'(c != 0));
			intReqFlags <= 8'h00;
			@(posedge core_clk);
		end
		stackFull <= 1'b0;
		// a request already pending at halt must not wake
		intReqFlags <= 8'h02;
		@(posedge core_clk);
		halt_now();
		repeat (20) @(posedge core_clk);
		#1;
		check("pending no wake", cpuRun, 32'h0);
		portAPin <= 8'hFE;
		wait_run(600);
		portAPin <= 8'hFF;
		intReqFlags <= 8'h00;
		check("masked irq", irq, 32'h0);
		// watchdog: stopped while disabled, then overflow wakes
		halt_now();
		repeat (1400) @(posedge core_clk);
		#1;
		check("wdt off stays", cpuRun, 32'h0);
		bus(1'b1, `HPW_OFS_WDTCTL, 32'h1);
		wait_run(2000);
		check("pc sp reset", pcSpReset, 32'h1);
		check("expiry set", wdtExpiryFlag, 32'h1);
		check("power-down same", powerDownFlag, 32'h1);
		check("irq raised", irq, 32'h1);
		bus(1'b0, `HPW_OFS_EVSTAT, 32'h0);
		check("events", rd, 32'h7);
		bus(1'b1, `HPW_OFS_EVSTAT, 32'h7);
		bus(1'b0, `HPW_OFS_EVSTAT, 32'h0);
		check("events cleared", rd, 32'h0);
		check("irq cleared", irq, 32'h0);
		// the watchdog keeps running; its next overflow asks for a device reset
		w = 0;
		while (wdtResetReq !== 1'b1 && w < 1500) begin
			@(posedge core_clk);
			#1;
			w++;
		end
		check("run overflow reset", wdtResetReq, 32'h1);
		check("run not halted", cpuRun, 32'h1);
		// a fresh halt clears the expiry flag left by the overflow wake
		halt_now();
		check("expiry cleared again", wdtExpiryFlag, 32'h0);
		check("power-down again", powerDownFlag, 32'h1);
		give_verdict();
	end
endmodule // hpw_ctrl_bench
